/* File: verilog/prmc_pkg.sv */
// paged register map constants: page codes, command codes, init values, timing
// assumes a single 200 MHz core clock and 14-bit register words
package prmc_pkg;
    // register word and address layout
    localparam int unsigned DATA_W      = 14;              // bits per register
    localparam int unsigned ADDR_W      = 9;               // full register address
    localparam int unsigned PAGE_W      = 3;               // upper address bits
    localparam int unsigned IDX_W       = 6;               // register inside a page
    localparam int unsigned PAGE_LSB    = 6;               // first page bit of the address
    localparam int unsigned CFG_DEPTH_D = 48;              // default config register count
    localparam int unsigned NV_SUM_N    = 2;               // nonvolatile checksum registers

    // page codes
    localparam logic [2:0] PAGE_MEAS    = 3'h1;            // measurement results
    localparam logic [2:0] PAGE_CFG     = 3'h2;            // device configuration
    localparam logic [2:0] PAGE_CMD     = 3'h3;            // command page
    localparam logic [2:0] PAGE_INT_A   = 3'h4;            // internal, holds nv checksums
    localparam logic [2:0] PAGE_INT_B   = 3'h5;            // internal

    // fixed locations
    localparam logic [5:0] IDX_FAULT    = 6'h3f;           // fault status, page 2
    localparam logic [5:0] IDX_NV_SUM0  = 6'h3e;           // nv checksum 0, page 4
    localparam logic [5:0] IDX_NV_SUM1  = 6'h3f;           // nv checksum 1, page 4
    localparam int unsigned FAULT_BIT   = 0;               // checksum fault flag position

    // command codes, carried in the register index of a page 3 write
    localparam logic [5:0] CMD_RESET    = 6'h01;           // reload init values
    localparam logic [5:0] CMD_CALC     = 6'h02;           // calculate signature
    localparam logic [5:0] CMD_CHECK    = 6'h03;           // check signature

    // init values
    localparam logic [13:0] CFG_INIT    = 14'h0000;        // plain config bits
    localparam logic [5:0]  PIN_REG     = 6'h00;           // register holding pin bits
    localparam logic [13:0] PIN_MASK    = 14'h000f;        // pin derived bits there
    localparam logic [5:0]  NV_REG      = 6'h01;           // register holding nv bits
    localparam logic [13:0] NV_MASK     = 14'h00ff;        // nv derived bits there

    // signature engine
    localparam logic [13:0] MISR_SEED   = 14'h0000;        // all zero start
    localparam logic [13:0] MISR_TAPS   = 14'h2b01;        // feedback taps

    // timing: core clock and longest command to response time
    localparam int unsigned CLK_MHZ     = 200;             // core_clk rate
    localparam int unsigned RESP_MAX_US = 156;             // two device stack, slow daisy
    localparam int unsigned RESP_MAX_CYC = RESP_MAX_US * CLK_MHZ; // longest, exact product, 31200 cycles

    // walk states
    typedef enum logic [2:0] {
        PRMC_IDLE   = 3'b001,
        PRMC_WALK   = 3'b010,
        PRMC_FINISH = 3'b100
    } prmc_phase_t;
endpackage : prmc_pkg

/* File: verilog/prmc_sig_if.sv */
// carrier between the register map and its signature engine
// assumes both ends run on core_clk
interface prmc_sig_if;
    logic        clr;    // restart from seed
    logic        en;     // fold one word
    logic [13:0] din;    // word to fold
    logic [13:0] sig;    // running signature
    modport eng  (output clr, output en, output din, input sig);
    modport misr (input clr, input en, input din, output sig);
endinterface : prmc_sig_if

/* File: verilog/prmc_misr.sv */
// fourteen bit multiple input shift register
// assumes the driver walks the covered words one per enabled cycle
module prmc_misr (
    // clock and reset
    input  wire logic  core_clk,
    input  wire logic  sys_rst,
    // fold port
    prmc_sig_if.misr   sig_port
);
    typedef struct packed {
        logic [13:0] sig;    // signature so far
    } prmc_misr_state_t;

    prmc_misr_state_t state;       // registered state
    prmc_misr_state_t next_state;  // value for next edge
    logic             fb;          // feedback bit

    // shift with tapped feedback, xor in the new word
    always_comb begin
        next_state = state;
        fb         = ^(state.sig & prmc_pkg::MISR_TAPS);
        if (sig_port.clr) begin
            next_state.sig = prmc_pkg::MISR_SEED;
        end else if (sig_port.en) begin
            next_state.sig = {state.sig[12:0], fb} ^ sig_port.din;
        end
    end

    // state register
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state.sig <= prmc_pkg::MISR_SEED;
        end else begin
            state <= next_state;
        end
    end

    assign sig_port.sig = state.sig;
endmodule : prmc_misr

/* File: verilog/prmc_regmap.sv */
// paged register map with configuration signature check
// assumes synchronous access strobes on core_clk, pins already synchronous
module prmc_regmap #(
    parameter int unsigned CFG_DEPTH    = prmc_pkg::CFG_DEPTH_D,  // config registers on page 2
    parameter int unsigned RESP_MAX_CYC = prmc_pkg::RESP_MAX_CYC  // response deadline in cycles
) (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    // register access from the host link
    input  wire logic        acc_valid,
    input  wire logic        acc_write,
    input  wire logic [8:0]  acc_addr,
    input  wire logic [13:0] acc_wdata,
    output logic             acc_ready,
    output logic             rd_valid,
    output logic [13:0]      rd_data,
    // measurement result source
    output logic [5:0]       meas_addr,
    input  wire logic [13:0] meas_data,
    // init sources
    input  wire logic        en_pin,
    input  wire logic [13:0] pin_bits,
    input  wire logic [13:0] nv_bits,
    input  wire logic [13:0] nv_sum0,
    input  wire logic [13:0] nv_sum1,
    // fault and engine control
    output logic             checksum_fault_flag,
    output logic             fault_notify,
    output logic             scan_allow,
    output logic             balance_allow,
    output logic             sig_busy
);
    localparam int unsigned WALK_N = CFG_DEPTH + prmc_pkg::NV_SUM_N; // covered words
    localparam logic [6:0]  WALK_LAST = 7'(WALK_N - 1);              // last walk index

    // refuse sizes the decode cannot serve, or whose walk passes the response deadline
    if (CFG_DEPTH < 2 || CFG_DEPTH > 63) begin : g_bad_depth
        $error("CFG_DEPTH must lie in 2..63");
    end
    if (WALK_N + 2 > RESP_MAX_CYC) begin : g_bad_deadline
        $error("signature walk exceeds response deadline");
    end

    typedef struct packed {
        logic [CFG_DEPTH-1:0][13:0] cfg;       // page 2 configuration
        logic [13:0]                sig_ref;   // last calculated signature
        logic                       fault;     // checksum fault flag
        prmc_pkg::prmc_phase_t      phase;     // walk state
        logic                       checking;  // walk is a check, not a calc
        logic [6:0]                 idx;       // walk position
        logic                       en_prev;   // enable pin last cycle
        logic                       rd_valid;  // read answer strobe
        logic [13:0]                rd_data;   // read answer word
        logic                       notify;    // fault notification pulse
    } prmc_state_t;

    prmc_state_t state;       // registered state
    prmc_state_t next_state;  // value for next edge

    prmc_sig_if sig_bus ();   // link to the signature engine

    // decoded access fields
    logic [2:0] acc_page;     // page number
    logic [5:0] acc_idx;      // register inside page
    logic       acc_take;     // access accepted this cycle
    logic       do_init;      // load init values
    logic       cfg_hit;      // address names a config register

    assign acc_page = acc_addr[8:prmc_pkg::PAGE_LSB];
    assign acc_idx  = acc_addr[prmc_pkg::PAGE_LSB-1:0];
    // accesses stall during a walk so the signed words stay still
    assign acc_ready = (state.phase == prmc_pkg::PRMC_IDLE);
    assign acc_take  = acc_valid && acc_ready;
    assign cfg_hit   = (acc_page == prmc_pkg::PAGE_CFG) && (32'(acc_idx) < CFG_DEPTH);
    assign meas_addr = acc_idx;

    // init on enable toggle or reset command; sys_rst covers power-up
    assign do_init = (en_pin != state.en_prev)
                  || (acc_take && acc_write && acc_page == prmc_pkg::PAGE_CMD
                      && acc_idx == prmc_pkg::CMD_RESET);

    // word fed to the engine: config in ascending order, then nv checksums
    always_comb begin
        sig_bus.din = state.idx[0] ? nv_sum1 : nv_sum0;
        if (32'(state.idx) < CFG_DEPTH) begin
            sig_bus.din = state.cfg[state.idx[5:0]];
        end
    end
    // walk control toward the engine
    assign sig_bus.en  = (state.phase == prmc_pkg::PRMC_WALK);
    assign sig_bus.clr = acc_take && acc_write && acc_page == prmc_pkg::PAGE_CMD
                      && (acc_idx == prmc_pkg::CMD_CALC || acc_idx == prmc_pkg::CMD_CHECK);

    prmc_misr u_misr (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .sig_port (sig_bus)
    );

    // next state: access decode, walk, fault handling
    always_comb begin
        logic fault_set;   // mismatch found this cycle
        logic fault_clr;   // host clears the flag this cycle
        fault_set  = 1'b0;
        fault_clr  = 1'b0;
        next_state = state;
        next_state.en_prev  = en_pin;
        next_state.rd_valid = 1'b0;
        next_state.notify   = 1'b0;

        // register accesses
        if (acc_take && !acc_write) begin
            next_state.rd_valid = 1'b1;
            next_state.rd_data  = 14'h0000;                    // unmapped reads zero
            unique case (acc_page)
                prmc_pkg::PAGE_MEAS: begin
                    next_state.rd_data = meas_data;
                end
                prmc_pkg::PAGE_CFG: begin
                    if (cfg_hit) begin
                        next_state.rd_data = state.cfg[acc_idx];
                    end else if (acc_idx == prmc_pkg::IDX_FAULT) begin
                        next_state.rd_data[prmc_pkg::FAULT_BIT] = state.fault;
                    end
                end
                prmc_pkg::PAGE_INT_A: begin
                    // only the nv checksums are visible here
                    if (acc_idx == prmc_pkg::IDX_NV_SUM0) begin
                        next_state.rd_data = nv_sum0;
                    end else if (acc_idx == prmc_pkg::IDX_NV_SUM1) begin
                        next_state.rd_data = nv_sum1;
                    end
                end
                default: begin
                    next_state.rd_data = 14'h0000;             // pages 0,3,5,6,7 read zero
                end
            endcase
        end else if (acc_take && acc_write) begin
            unique case (acc_page)
                prmc_pkg::PAGE_CFG: begin
                    if (cfg_hit) begin
                        next_state.cfg[acc_idx] = acc_wdata;
                    end else if (acc_idx == prmc_pkg::IDX_FAULT) begin
                        fault_clr = acc_wdata[prmc_pkg::FAULT_BIT];
                    end
                end
                prmc_pkg::PAGE_CMD: begin
                    // command page stores nothing
                    if (acc_idx == prmc_pkg::CMD_CALC || acc_idx == prmc_pkg::CMD_CHECK) begin
                        next_state.phase    = prmc_pkg::PRMC_WALK;
                        next_state.checking = (acc_idx == prmc_pkg::CMD_CHECK);
                        next_state.idx      = 7'h00;
                    end
                end
                default: begin
                    next_state.phase = state.phase;            // other pages ignore writes
                end
            endcase
        end

        // signature walk over covered words only; pages 1 and 3 never enter it
        unique case (state.phase)
            prmc_pkg::PRMC_IDLE: begin
                next_state.idx = next_state.idx;
            end
            prmc_pkg::PRMC_WALK: begin
                next_state.idx = state.idx + 7'h01;
                if (state.idx == WALK_LAST) begin
                    next_state.phase = prmc_pkg::PRMC_FINISH;
                end
            end
            prmc_pkg::PRMC_FINISH: begin
                next_state.phase = prmc_pkg::PRMC_IDLE;
                if (!state.checking) begin
                    next_state.sig_ref = sig_bus.sig;
                end else if (sig_bus.sig != state.sig_ref) begin
                    fault_set = 1'b1;
                end
            end
            default: begin
                next_state.phase = prmc_pkg::PRMC_IDLE;        // recover from bad code
            end
        endcase

        // a mismatch in the clearing cycle wins over the clear
        if (fault_set) begin
            next_state.fault  = 1'b1;
            next_state.notify = 1'b1;
        end else if (fault_clr) begin
            next_state.fault  = 1'b0;
        end

        // init reloads config; pin and nv bits from their sources
        if (do_init) begin
            for (int i = 0; i < CFG_DEPTH; i++) begin
                next_state.cfg[i] = prmc_pkg::CFG_INIT;
            end
            next_state.cfg[prmc_pkg::PIN_REG] = (prmc_pkg::CFG_INIT & ~prmc_pkg::PIN_MASK)
                                              | (pin_bits & prmc_pkg::PIN_MASK);
            next_state.cfg[prmc_pkg::NV_REG]  = (prmc_pkg::CFG_INIT & ~prmc_pkg::NV_MASK)
                                              | (nv_bits & prmc_pkg::NV_MASK);
            next_state.fault    = 1'b0;
            next_state.sig_ref  = prmc_pkg::MISR_SEED;
            next_state.phase    = prmc_pkg::PRMC_IDLE;
            next_state.checking = 1'b0;
            next_state.idx      = 7'h00;
        end
    end

    // state register; pin and nv sources are caught by the first edge after release only if en_pin is high then
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < CFG_DEPTH; i++) begin
                state.cfg[i] <= prmc_pkg::CFG_INIT;
            end
            state.sig_ref  <= prmc_pkg::MISR_SEED;
            state.fault    <= 1'b0;
            state.phase    <= prmc_pkg::PRMC_IDLE;
            state.checking <= 1'b0;
            state.idx      <= 7'h00;
            state.en_prev  <= 1'b0;
            state.rd_valid <= 1'b0;
            state.rd_data  <= 14'h0000;
            state.notify   <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // outputs
    assign rd_valid            = state.rd_valid;
    assign rd_data             = state.rd_data;
    assign checksum_fault_flag = state.fault;
    assign fault_notify        = state.notify;
    assign scan_allow          = !state.fault;
    assign balance_allow       = !state.fault;
    assign sig_busy            = (state.phase != prmc_pkg::PRMC_IDLE);
endmodule : prmc_regmap

/* File: tb/prmc_far_src.sv */
// far side source model: measurement words, pin levels, eeprom bits and sums
// assumes it feeds the regmap measurement and init inputs directly
module prmc_far_src #(
    parameter logic [13:0] PINS = 14'h0000,  // pin levels
    parameter logic [13:0] NVB  = 14'h0000,  // eeprom bits
    parameter logic [13:0] SUM0 = 14'h0000,  // eeprom checksum 0
    parameter logic [13:0] SUM1 = 14'h0000   // eeprom checksum 1
) (
    // measurement lookup
    input  wire logic [5:0]  meas_addr,
    output logic      [13:0] meas_data,
    // init sources
    output logic      [13:0] pin_bits,
    output logic      [13:0] nv_bits,
    output logic      [13:0] nv_sum0,
    output logic      [13:0] nv_sum1
);
    timeunit 1ns;
    timeprecision 1ps;
    // word stamped with its index, so a wrong index shows
    assign meas_data = {8'ha5, meas_addr};
    // static sources, always driven
    assign pin_bits  = PINS;
    assign nv_bits   = NVB;
    assign nv_sum0   = SUM0;
    assign nv_sum1   = SUM1;
endmodule : prmc_far_src

/* File: tb/prmc_regmap_assertions.sv */
// checker for the paged register map: reads, command walk, fault and init
// assumes it is bound into prmc_regmap and sees only its ports
module prmc_regmap_assertions #(
    parameter int unsigned CFG_DEPTH = prmc_pkg::CFG_DEPTH_D  // config registers
) (
    // clock and reset
    input wire logic        core_clk,
    input wire logic        sys_rst,
    // register access
    input wire logic        acc_valid,
    input wire logic        acc_write,
    input wire logic [8:0]  acc_addr,
    input wire logic        acc_ready,
    input wire logic        rd_valid,
    input wire logic [13:0] rd_data,
    // measurement and init
    input wire logic [13:0] meas_data,
    input wire logic        en_pin,
    // fault and engine
    input wire logic        checksum_fault_flag,
    input wire logic        fault_notify,
    input wire logic        scan_allow,
    input wire logic        balance_allow,
    input wire logic        sig_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    logic       take_rd;   // read taken this edge
    logic       take_cmd;  // calc or check taken
    logic [6:0] busy_cnt;  // busy cycles so far
    assign take_rd  = acc_valid && acc_ready && !acc_write;
    assign take_cmd = acc_valid && acc_ready && acc_write && (acc_addr[8:6] == prmc_pkg::PAGE_CMD)
                      && (acc_addr[5:0] == prmc_pkg::CMD_CALC || acc_addr[5:0] == prmc_pkg::CMD_CHECK);
    // walk length counter, cleared whenever idle
    always_ff @(posedge core_clk) begin
        if (sys_rst || !sig_busy) begin
            busy_cnt <= 7'h00;
        end else begin
            busy_cnt <= busy_cnt + 7'h01;
        end
    end
    rd_answer_a: assert property (take_rd |=> rd_valid)
        else $error("read not answered next cycle");
    rd_cause_a: assert property (rd_valid |-> $past(take_rd))
        else $error("read answer without a read");
    meas_read_a: assert property (take_rd && acc_addr[8:6] == prmc_pkg::PAGE_MEAS
        |=> rd_data == $past(meas_data)) else $error("page one read not measurement");
    cmd_start_a: assert property (take_cmd |=> sig_busy)
        else $error("command did not start walk");
    busy_refuse_a: assert property (sig_busy |-> !acc_ready)
        else $error("access accepted during walk");
    busy_len_a: assert property ($fell(sig_busy)
        |-> busy_cnt == 7'(CFG_DEPTH + prmc_pkg::NV_SUM_N + 1)) else $error("walk length wrong");
    fault_halt_a: assert property (scan_allow == !checksum_fault_flag
        && balance_allow == !checksum_fault_flag) else $error("scan or balance not halted");
    notify_end_a: assert property (fault_notify |-> checksum_fault_flag && $fell(sig_busy))
        else $error("notify outside walk end");
    notify_pulse_a: assert property (fault_notify |=> !fault_notify)
        else $error("notify longer than one cycle");
    fault_cause_a: assert property ($rose(checksum_fault_flag) |-> fault_notify)
        else $error("fault set without notify");
    init_clear_a: assert property ($changed(en_pin) |=> !checksum_fault_flag)
        else $error("enable toggle did not clear fault");
    // main scenarios reached
    cover property (fault_notify);
    cover property ($fell(sig_busy));
    cover property (take_rd && acc_addr[8:6] == prmc_pkg::PAGE_MEAS);
    cover property ($changed(en_pin));
endmodule : prmc_regmap_assertions

bind prmc_regmap prmc_regmap_assertions #(.CFG_DEPTH(CFG_DEPTH)) prmc_regmap_assertions_inst (
    .core_clk(core_clk), .sys_rst(sys_rst), .acc_valid(acc_valid), .acc_write(acc_write),
    .acc_addr(acc_addr), .acc_ready(acc_ready), .rd_valid(rd_valid), .rd_data(rd_data),
    .meas_data(meas_data), .en_pin(en_pin), .checksum_fault_flag(checksum_fault_flag),
    .fault_notify(fault_notify), .scan_allow(scan_allow), .balance_allow(balance_allow),
    .sig_busy(sig_busy));

/* File: tb/tb_prmc_regmap.sv */
// self-checking bench for the paged register map
// assumes design files compile first; one 200 MHz clock, synchronous reset
module tb_prmc_regmap;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned DEPTH = 2;                       // short config page
    localparam int unsigned WALK  = DEPTH + prmc_pkg::NV_SUM_N + 1; // busy cycles
    localparam logic [13:0] PINS = 14'h3ffa, NVB = 14'h1e5c; // init sources
    localparam logic [13:0] SUM0 = 14'h0123, SUM1 = 14'h2345; // eeprom sums
    typedef struct packed {logic wr; logic [8:0] addr; logic [13:0] wdata; logic [13:0] exp;} prmc_row_t;
    logic        core_clk, sys_rst, acc_valid, acc_write, acc_ready, rd_valid, en_pin;
    logic        checksum_fault_flag, fault_notify, scan_allow, balance_allow, sig_busy;
    logic [8:0]  acc_addr;
    logic [5:0]  meas_addr;
    logic [13:0] acc_wdata, rd_data, meas_data, pin_bits, nv_bits, nv_sum0, nv_sum1, got, c0, c1;
    int          bad_count, checks;
    // plain rows: write then read back, or read only
    prmc_row_t rows [9] = '{'{1'b0, 9'h0bf, 14'h0000, 14'h0000}, '{1'b1, 9'h080, 14'h3abc, 14'h3abc},
        '{1'b1, 9'h081, 14'h1555, 14'h1555}, '{1'b1, 9'h050, 14'h3fff, 14'h2950},
        '{1'b1, 9'h13e, 14'h0000, SUM0}, '{1'b0, 9'h13f, 14'h0000, SUM1},
        '{1'b1, 9'h145, 14'h3333, 14'h0000}, '{1'b1, 9'h090, 14'h1111, 14'h0000},
        '{1'b0, 9'h1c0, 14'h0000, 14'h0000}};
    prmc_regmap #(.CFG_DEPTH(DEPTH), .RESP_MAX_CYC(8)) prmc_regmap_inst (.core_clk(core_clk),
        .sys_rst(sys_rst), .acc_valid(acc_valid), .acc_write(acc_write), .acc_addr(acc_addr),
        .acc_wdata(acc_wdata), .acc_ready(acc_ready), .rd_valid(rd_valid), .rd_data(rd_data),
        .meas_addr(meas_addr), .meas_data(meas_data), .en_pin(en_pin), .pin_bits(pin_bits),
        .nv_bits(nv_bits), .nv_sum0(nv_sum0), .nv_sum1(nv_sum1), .checksum_fault_flag(checksum_fault_flag),
        .fault_notify(fault_notify), .scan_allow(scan_allow), .balance_allow(balance_allow), .sig_busy(sig_busy));
    prmc_far_src #(.PINS(PINS), .NVB(NVB), .SUM0(SUM0), .SUM1(SUM1)) prmc_far_src_inst (.meas_addr(meas_addr),
        .meas_data(meas_data), .pin_bits(pin_bits), .nv_bits(nv_bits), .nv_sum0(nv_sum0), .nv_sum1(nv_sum1));
    // free running clock
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    task automatic check(input logic [13:0] seen, input logic [13:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim
    // inputs move a fixed 1 ns after each rising edge
    task automatic tick;
        @(posedge core_clk);
        #1;
    endtask : tick
    // one access; waits for ready under a bound, read answer checked next cycle
    task automatic acc(input logic wr, input logic [8:0] addr, input logic [13:0] data);
        int k;
        k = 0;
        tick(); // an idle edge between calls, so valid never drops and rises in one step
        while (acc_ready !== 1'b1) begin
            tick();
            k++;
            if (k > 100) begin
                bad_count++;
                end_sim();
            end
        end
        acc_valid = 1'b1;
        acc_write = wr;
        acc_addr  = addr;
        acc_wdata = data;
        tick();
        acc_valid = 1'b0;
        if (!wr) begin
            check({13'h0000, rd_valid}, 14'h0001);
            got = rd_data;
        end
    endtask : acc
    // command write, then count busy cycles under a bound
    task automatic cmd(input logic [5:0] code, input int busy_exp);
        int k;
        acc(1'b1, {prmc_pkg::PAGE_CMD, code}, 14'h0000);
        k = 0;
        while (sig_busy === 1'b1 && k < 100) begin
            tick();
            k++;
        end
        check(14'(k), 14'(busy_exp));
        // a walk that never ends is a hang, close the run
        if (k >= 100) begin
            bad_count++;
            end_sim();
        end
    endtask : cmd
    // expected signature step, and its inverse to build a zero signature
    function automatic logic [13:0] fold(input logic [13:0] s, input logic [13:0] w);
        return {s[12:0], ^(s & prmc_pkg::MISR_TAPS)} ^ w;
    endfunction : fold
    function automatic logic [13:0] unfold(input logic [13:0] y);
        logic [13:0] s;
        s = {1'b0, y[13:1]};
        s[13] = y[0] ^ (^(s & prmc_pkg::MISR_TAPS));
        return s;
    endfunction : unfold
    // config words after any init
    task automatic check_init;
        acc(1'b0, 9'h080, 14'h0000);
        check(got, (prmc_pkg::CFG_INIT & ~prmc_pkg::PIN_MASK) | (PINS & prmc_pkg::PIN_MASK));
        acc(1'b0, 9'h081, 14'h0000);
        check(got, (prmc_pkg::CFG_INIT & ~prmc_pkg::NV_MASK) | (NVB & prmc_pkg::NV_MASK));
    endtask : check_init
    initial begin
        bad_count = 0;
        checks = 0;
        sys_rst = 1'b1;
        {acc_valid, acc_write, en_pin, acc_addr, acc_wdata} = '0;
        repeat (2) @(posedge core_clk);
        #1 sys_rst = 1'b0;
        tick();
        check({9'h000, acc_ready, scan_allow, balance_allow, sig_busy, checksum_fault_flag}, 14'h001c);
        acc(1'b0, 9'h080, 14'h0000);
        check(got, prmc_pkg::CFG_INIT);
        $display("test reset done");
        foreach (rows[i]) begin
            if (rows[i].wr) acc(1'b1, rows[i].addr, rows[i].wdata);
            acc(1'b0, rows[i].addr, 14'h0000);
            check(got, rows[i].exp);
        end
        $display("test table done");
        // config whose signature folds to zero, checked with no prior calculate
        c0 = 14'h3abc;
        c1 = fold(c0, unfold(unfold(SUM1) ^ SUM0));
        acc(1'b1, 9'h080, c0);
        acc(1'b1, 9'h081, c1);
        cmd(prmc_pkg::CMD_CHECK, WALK);
        check({12'h000, checksum_fault_flag, fault_notify}, 14'h0000);
        acc(1'b1, 9'h081, c1 ^ 14'h0001);
        cmd(prmc_pkg::CMD_CHECK, WALK);
        check({12'h000, checksum_fault_flag, fault_notify}, 14'h0003);
        check({12'h000, scan_allow, balance_allow}, 14'h0000);
        tick();
        check({13'h0000, fault_notify}, 14'h0000);
        acc(1'b1, 9'h081, c1);
        acc(1'b1, 9'h0bf, 14'h0001);
        check({13'h0000, checksum_fault_flag}, 14'h0000);
        $display("test signature done");
        // calculate, unknown code, then check against the stored value
        acc(1'b1, 9'h081, 14'h2aaa);
        cmd(prmc_pkg::CMD_CALC, WALK);
        cmd(6'h05, 0);
        acc(1'b1, 9'h04f, 14'h1234);
        cmd(prmc_pkg::CMD_CHECK, WALK);
        check({13'h0000, checksum_fault_flag}, 14'h0000);
        $display("test calculate done");
        // fault, then enable toggle and reset command both reinitialise
        acc(1'b1, 9'h080, 14'h0f0f);
        cmd(prmc_pkg::CMD_CHECK, WALK);
        check({13'h0000, checksum_fault_flag}, 14'h0001);
        en_pin = 1'b1;
        tick();
        check({13'h0000, checksum_fault_flag}, 14'h0000);
        check_init();
        acc(1'b1, 9'h080, 14'h1111);
        cmd(prmc_pkg::CMD_RESET, 0);
        check_init();
        $display("test init done");
        end_sim();
    end
endmodule : tb_prmc_regmap
